// ===== rtl/lp_pin_pkg.sv
// package: shared constants and types for the low-power pin state controller
package lp_pin_pkg;

    // ****************************************
    // power state machine
    // ****************************************
    typedef enum logic [4:0] {
        ST_RESET  = 5'h01,
        ST_NORMAL = 5'h02,
        ST_SLEEP  = 5'h04,
        ST_PSTOP  = 5'h08,
        ST_SSTOP  = 5'h10
    } power_state_type;

    // requested mode codes from the core
    localparam logic [1:0] MODE_NORMAL = 2'h0;
    localparam logic [1:0] MODE_SLEEP  = 2'h1;
    localparam logic [1:0] MODE_PSTOP  = 2'h2;
    localparam logic [1:0] MODE_SSTOP  = 2'h3;

    // ****************************************
    // pin input bundle layout
    // ****************************************
    localparam int PIN_IN_W       = 7;
    localparam int PIN_RX1        = 0;
    localparam int PIN_ASYNC1_CLEAR_TO_SEND       = 1;
    localparam int PIN_CSIO_RX    = 2;
    localparam int PIN_DMA0_REQUEST_IN      = 3;
    localparam int PIN_DMA1_REQUEST_IN      = 4;
    localparam int PIN_ASYNC1_CLK = 5;
    localparam int PIN_CSIO_CLK   = 6;

    // idle level of every pin input (all idle high)
    localparam logic [PIN_IN_W-1:0] PIN_IN_IDLE = 7'h7f;

    // ****************************************
    // reset values and decode
    // ****************************************
    localparam logic       STROBE_IDLE   = 1'b1;
    localparam logic       TX_IDLE       = 1'b1;
    localparam logic       HALT_LOW      = 1'b0;
    localparam logic       PCLK_RESET    = 1'b0;
    localparam logic [7:0] IO_UPPER_PAGE = 8'h00;

endpackage

// ===== rtl/lp_sync_if.sv
// interface: raw pin bits and their debounced, synchronised copy
`timescale 1ns/10ps
interface lp_sync_if #(
    parameter int WIDTH = 7
);
    logic [WIDTH-1:0] raw;
    logic [WIDTH-1:0] clean;

    modport producer (output raw, input clean);
    modport syncer   (input raw, output clean);
endinterface

// ===== rtl/lp_pin_sync.sv
// module: three-stage synchroniser, change accepted when stages two and three agree
`timescale 1ns/10ps
module lp_pin_sync #(
    parameter int                 WIDTH     = 7,
    parameter logic [WIDTH-1:0]   RESET_VAL = '1
) (
    input  wire logic     i_ref_clk,
    input  wire logic     i_rst,
    lp_sync_if.syncer     sync
);

    // ****************************************
    // elaboration check
    // ****************************************
    if (WIDTH < 1) begin : g_bad_width
        $error("lp_pin_sync: WIDTH must be at least 1");
    end

    // ****************************************
    // per-bit stages
    // ****************************************
    for (genvar b = 0; b < WIDTH; b++) begin : g_bit
        logic s1_reg;
        logic s2_reg;
        logic s3_reg;
        logic out_reg;
        wire  agree = (s2_reg == s3_reg);

        // first stage is read only by the second
        always_ff @(posedge i_ref_clk) begin
            if (i_rst) begin
                s1_reg  <= RESET_VAL[b];
                s2_reg  <= RESET_VAL[b];
                s3_reg  <= RESET_VAL[b];
                out_reg <= RESET_VAL[b];
            end else begin
                s1_reg  <= sync.raw[b];
                s2_reg  <= s1_reg;
                s3_reg  <= s2_reg;
                out_reg <= agree ? s3_reg : out_reg;
            end
        end

        assign sync.clean[b] = out_reg;
    end

endmodule

// ===== rtl/lp_pin_ctrl.sv
// module: pin state control for reset, sleep, peripheral stop and system stop
//
// Functional notes
// - internal register block decoded at programmable page
// - bus strobes other than halt idle high except peripheral stop, halt held low in sleep and system stop
// - transmit outputs high in reset, frozen in stops
// - serial inputs ignored in peripheral stop, DMA requests ignored in sleep
`timescale 1ns/10ps
module lp_pin_ctrl
    import lp_pin_pkg::*;
(
    input  wire logic        i_ref_clk,
    input  wire logic        i_rst,
    // mode request and configuration from the core
    input  wire logic [1:0]  i_mode_req,
    input  wire logic        i_async1_clk_internal,
    input  wire logic        i_csio_clk_internal,
    input  wire logic        i_io_base_bit_high,
    input  wire logic        i_io_base_bit_low,
    // internal register decode
    input  wire logic        i_io_cycle,
    input  wire logic [15:0] i_io_addr,
    output logic             o_internal_select,
    // core-side strobe levels (active low, as they would appear on the pins), then transmit data and serial clocks
    input  wire logic        i_core_rd_n,
    input  wire logic        i_core_wr_n,
    input  wire logic        i_core_memory_request_strobe_n,
    input  wire logic        i_core_io_request_strobe_n,
    input  wire logic        i_core_refresh_strobe_n,
    input  wire logic        i_core_first_cycle_strobe_n,
    input  wire logic        i_core_dma0_transfer_end_n,
    input  wire logic        i_core_dma1_transfer_end_n,
    input  wire logic        i_core_halt_n,
    input  wire logic        i_core_async1_transmit,
    input  wire logic        i_core_clocked_serial_transmit,
    input  wire logic        i_core_async1_clk,
    input  wire logic        i_core_csio_clk,
    // pins: strobes
    output logic             o_rd_n,
    output logic             o_wr_n,
    output logic             o_memory_request_strobe_n,
    output logic             o_io_request_strobe_n,
    output logic             o_refresh_strobe_n,
    output logic             o_first_cycle_strobe_n,
    output logic             o_dma0_transfer_end_n,
    output logic             o_dma1_transfer_end_n,
    output logic             o_halt_n,
    // pins: clocks
    output logic             o_sys_clk,
    output logic             o_periph_clk,
    // pins: serial outputs
    output logic             o_async1_transmit_out,
    output logic             o_clocked_serial_transmit_out,
    // pins: serial clocks (two-way)
    input  wire logic        i_async1_clock_pin,
    output logic             o_async1_clock_pin,
    output logic             o_async1_clock_pin_oe,
    input  wire logic        i_clocked_serial_clock_pin,
    output logic             o_clocked_serial_clock_pin,
    output logic             o_clocked_serial_clock_pin_oe,
    // pins: inputs
    input  wire logic        i_async1_receive_in,
    input  wire logic        i_async1_clear_to_send_n,
    input  wire logic        i_clocked_serial_receive_in,
    input  wire logic        i_dma0_request_in_n,
    input  wire logic        i_dma1_request_in_n,
    // gated inputs towards the core
    output logic             o_core_async1_receive,
    output logic             o_core_async1_clear_to_send_n,
    output logic             o_core_clocked_serial_receive,
    output logic             o_core_dma0_request_n,
    output logic             o_core_dma1_request_n,
    output logic             o_core_async1_clk,
    output logic             o_core_csio_clk,
    output logic [4:0]       o_power_state
);

    // ****************************************
    // declarations
    // ****************************************
    power_state_type        state_reg;
    power_state_type        state_next;
    logic                   sys_clk_reg = 1'b0;   // free-running, never reset
    logic                   periph_clk_reg;
    logic [PIN_IN_W-1:0]    pin_clean;
    logic                   sel_reg;
    logic [8:0]             strobe_reg;
    logic [1:0]             tx_reg;
    logic [6:0]             in_reg;
    logic [3:0]             ck_reg;

    lp_sync_if #(.WIDTH(PIN_IN_W)) pin_sync ();

    // ****************************************
    // input synchroniser
    // ****************************************
    assign pin_sync.raw = {i_clocked_serial_clock_pin, i_async1_clock_pin, i_dma1_request_in_n,
                           i_dma0_request_in_n, i_clocked_serial_receive_in,
                           i_async1_clear_to_send_n, i_async1_receive_in};
    assign pin_clean    = pin_sync.clean;

    lp_pin_sync #(
        .WIDTH     (PIN_IN_W),
        .RESET_VAL (PIN_IN_IDLE)
    ) u_sync (
        .i_ref_clk (i_ref_clk),
        .i_rst     (i_rst),
        .sync      (pin_sync)
    );

    // ****************************************
    // state decode
    // ****************************************
    wire in_reset   = (state_reg == ST_RESET);
    wire in_normal  = (state_reg == ST_NORMAL);
    wire in_sleep   = (state_reg == ST_SLEEP);
    wire in_pstop   = (state_reg == ST_PSTOP);
    wire in_sstop   = (state_reg == ST_SSTOP);
    wire any_stop   = in_pstop | in_sstop;
    wire serial_on  = in_normal | in_sleep;
    wire bus_on     = in_normal | in_pstop;

    // next state follows the core request
    always_comb begin
        case (i_mode_req)
            MODE_NORMAL: state_next = ST_NORMAL;
            MODE_SLEEP:  state_next = ST_SLEEP;
            MODE_PSTOP:  state_next = ST_PSTOP;
            MODE_SSTOP:  state_next = ST_SSTOP;
            default:     state_next = ST_NORMAL;
        endcase
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            state_reg <= ST_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // ****************************************
    // register block decode
    // ****************************************
    wire [1:0] io_base  = {i_io_base_bit_high, i_io_base_bit_low};
    wire       sel_next = i_io_cycle && (i_io_addr[15:8] == IO_UPPER_PAGE)
                          && (i_io_addr[7:6] == io_base);

    // ****************************************
    // bus strobes
    // ****************************************
    wire [8:0] core_strobes = {i_core_halt_n, i_core_dma1_transfer_end_n,
                               i_core_dma0_transfer_end_n, i_core_first_cycle_strobe_n,
                               i_core_refresh_strobe_n, i_core_io_request_strobe_n,
                               i_core_memory_request_strobe_n, i_core_wr_n, i_core_rd_n};
    wire       halt_next    = bus_on ? i_core_halt_n : (in_reset ? STROBE_IDLE : HALT_LOW);
    wire [8:0] strobe_next  = {halt_next,
                               bus_on ? core_strobes[7:0] : {8{STROBE_IDLE}}};

    // ****************************************
    // transmit outputs
    // ****************************************
    wire [1:0] core_tx = {i_core_clocked_serial_transmit, i_core_async1_transmit};
    wire [1:0] tx_next = serial_on ? core_tx : tx_reg;

    // ****************************************
    // gated inputs
    // ****************************************
    wire       ext_a1  = ~i_async1_clk_internal;
    wire       ext_cs  = ~i_csio_clk_internal;
    wire [2:0] ser_in  = serial_on ? pin_clean[PIN_CSIO_RX:PIN_RX1] : PIN_IN_IDLE[2:0];
    wire [1:0] dma_in  = bus_on ? pin_clean[PIN_DMA1_REQUEST_IN:PIN_DMA0_REQUEST_IN] : PIN_IN_IDLE[4:3];
    wire [1:0] clk_in  = {(serial_on && ext_cs) ? pin_clean[PIN_CSIO_CLK] : PIN_IN_IDLE[6],
                          (serial_on && ext_a1) ? pin_clean[PIN_ASYNC1_CLK] : PIN_IN_IDLE[5]};
    wire [6:0] in_next = {clk_in, dma_in, ser_in};

    // ****************************************
    // serial clock pins
    // ****************************************
    wire a1_oe  = serial_on && i_async1_clk_internal;
    wire cs_oe  = (serial_on || any_stop) && i_csio_clk_internal;
    wire cs_out = any_stop ? 1'b1 : i_core_csio_clk;
    wire [3:0] ck_next = {cs_oe, cs_out, a1_oe, i_core_async1_clk};

    // output registers
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            sel_reg    <= 1'b0;
            strobe_reg <= {9{STROBE_IDLE}};
            tx_reg     <= {2{TX_IDLE}};
            in_reg     <= PIN_IN_IDLE;
            ck_reg     <= 4'h0;
        end else begin
            sel_reg    <= sel_next;
            strobe_reg <= strobe_next;
            tx_reg     <= tx_next;
            in_reg     <= in_next;
            ck_reg     <= ck_next;
        end
    end

    // ****************************************
    // clock outputs
    // ****************************************
    // system clock runs through reset as well
    always_ff @(posedge i_ref_clk) begin
        sys_clk_reg <= ~sys_clk_reg;
    end

    // peripheral clock: half the system clock, held low in reset
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            periph_clk_reg <= PCLK_RESET;
        end else if (sys_clk_reg) begin
            periph_clk_reg <= ~periph_clk_reg;
        end
    end

    // ****************************************
    // port mapping
    // ****************************************
    assign o_internal_select             = sel_reg;
    assign o_rd_n                        = strobe_reg[0];
    assign o_wr_n                        = strobe_reg[1];
    assign o_memory_request_strobe_n     = strobe_reg[2];
    assign o_io_request_strobe_n         = strobe_reg[3];
    assign o_refresh_strobe_n            = strobe_reg[4];
    assign o_first_cycle_strobe_n        = strobe_reg[5];
    assign o_dma0_transfer_end_n         = strobe_reg[6];
    assign o_dma1_transfer_end_n         = strobe_reg[7];
    assign o_halt_n                      = strobe_reg[8];
    assign o_sys_clk                     = sys_clk_reg;
    assign o_periph_clk                  = periph_clk_reg;
    assign o_async1_transmit_out         = tx_reg[0];
    assign o_clocked_serial_transmit_out = tx_reg[1];
    assign o_async1_clock_pin            = ck_reg[0];
    assign o_async1_clock_pin_oe         = ck_reg[1];
    assign o_clocked_serial_clock_pin    = ck_reg[2];
    assign o_clocked_serial_clock_pin_oe = ck_reg[3];
    assign o_core_async1_receive         = in_reg[0];
    assign o_core_async1_clear_to_send_n = in_reg[1];
    assign o_core_clocked_serial_receive = in_reg[2];
    assign o_core_dma0_request_n         = in_reg[3];
    assign o_core_dma1_request_n         = in_reg[4];
    assign o_core_async1_clk             = in_reg[5];
    assign o_core_csio_clk               = in_reg[6];
    assign o_power_state                 = state_reg;

endmodule

// ===== bench/lp_pin_ctrl_monitor.sv
// checker: pin state assertions for the low-power pin controller
`timescale 1ns/10ps
module lp_pin_ctrl_monitor (
    input wire logic        i_ref_clk,
    input wire logic        i_rst,
    input wire logic        i_io_cycle,
    input wire logic [15:0] i_io_addr,
    input wire logic        i_io_base_bit_high,
    input wire logic        i_io_base_bit_low,
    input wire logic        o_internal_select,
    input wire logic        i_core_rd_n,
    input wire logic        i_core_wr_n,
    input wire logic        i_core_halt_n,
    input wire logic        i_core_async1_transmit,
    input wire logic        i_core_clocked_serial_transmit,
    input wire logic        i_csio_clk_internal,
    input wire logic        o_rd_n,
    input wire logic        o_wr_n,
    input wire logic        o_memory_request_strobe_n,
    input wire logic        o_io_request_strobe_n,
    input wire logic        o_refresh_strobe_n,
    input wire logic        o_first_cycle_strobe_n,
    input wire logic        o_dma0_transfer_end_n,
    input wire logic        o_dma1_transfer_end_n,
    input wire logic        o_halt_n,
    input wire logic        o_sys_clk,
    input wire logic        o_periph_clk,
    input wire logic        o_async1_transmit_out,
    input wire logic        o_clocked_serial_transmit_out,
    input wire logic        o_async1_clock_pin_oe,
    input wire logic        o_clocked_serial_clock_pin,
    input wire logic        o_clocked_serial_clock_pin_oe,
    input wire logic        o_core_async1_receive,
    input wire logic        o_core_clocked_serial_receive,
    input wire logic        o_core_dma0_request_n,
    input wire logic        o_core_dma1_request_n,
    input wire logic [4:0]  o_power_state
);
    // ****************************************
    // helper decode
    // ****************************************
    // all bus strobes except halt, and state flags
    wire logic [7:0] strb = {o_rd_n, o_wr_n, o_memory_request_strobe_n, o_io_request_strobe_n,
                             o_refresh_strobe_n, o_first_cycle_strobe_n, o_dma0_transfer_end_n, o_dma1_transfer_end_n};
    wire logic       in_rst   = o_power_state == 5'h01;
    wire logic       in_sleep = o_power_state == 5'h04;
    wire logic       in_pstop = o_power_state == 5'h08;
    wire logic       in_stop  = in_pstop || o_power_state == 5'h10;
    wire logic       hit      = i_io_cycle && i_io_addr[15:8] == 8'h00
                                && i_io_addr[7:6] == {i_io_base_bit_high, i_io_base_bit_low};

    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);

    // ****************************************
    // assertions
    // ****************************************
    decode_select_a: assert property (1'b1 |=> o_internal_select == $past(hit))
        else $error("internal select does not match page decode");
    strobe_idle_a: assert property ((in_sleep || o_power_state == 5'h10) |=> strb == 8'hff && !o_halt_n)
        else $error("strobes not idle in sleep or system stop");
    strobe_pass_a: assert property (in_pstop |=> o_rd_n == $past(i_core_rd_n)
        && o_wr_n == $past(i_core_wr_n) && o_halt_n == $past(i_core_halt_n))
        else $error("strobes not passed in peripheral stop");
    reset_pins_a: assert property (in_rst |=> strb == 8'hff && o_halt_n
        && o_async1_transmit_out && o_clocked_serial_transmit_out
        && !o_async1_clock_pin_oe && !o_clocked_serial_clock_pin_oe)
        else $error("pin levels wrong after reset state");
    tx_freeze_a: assert property (in_stop |=> $stable(o_async1_transmit_out)
        && $stable(o_clocked_serial_transmit_out))
        else $error("transmit outputs moved during stop");
    tx_follow_a: assert property (in_sleep |=> o_async1_transmit_out == $past(i_core_async1_transmit)
        && o_clocked_serial_transmit_out == $past(i_core_clocked_serial_transmit))
        else $error("transmit outputs not following core in sleep");
    dma_ignored_a: assert property (in_sleep [*8] |-> o_core_dma0_request_n && o_core_dma1_request_n)
        else $error("dma requests seen in sleep");
    serial_ignored_a: assert property (in_pstop [*8] |-> o_core_async1_receive && o_core_clocked_serial_receive)
        else $error("serial inputs seen in peripheral stop");
    pclk_reset_a: assert property (in_rst |-> !o_periph_clk)
        else $error("peripheral clock high in reset state");
    sclk_run_a: assert property (1'b1 |=> o_sys_clk != $past(o_sys_clk))
        else $error("system clock stopped");
    csio_clk_stop_a: assert property (in_stop && i_csio_clk_internal |=> o_clocked_serial_clock_pin_oe
        && o_clocked_serial_clock_pin && !o_async1_clock_pin_oe)
        else $error("serial clock pins wrong in stop");
endmodule

bind lp_pin_ctrl lp_pin_ctrl_monitor u_mon (.*);

// ===== bench/link_partner_model.sv
// model: far-side serial and dma devices driving the pin inputs
`timescale 1ns/10ps
module link_partner_model (
    input  wire logic       i_assert,
    input  wire logic [1:0] i_oe,
    input  wire logic [1:0] i_clk_out,
    output logic      [6:0] o_pins
);
    // clock pins follow the controller while it drives, else the far side's level
    assign o_pins[6]   = i_oe[1] ? i_clk_out[1] : !i_assert;   // clocked serial clock pin
    assign o_pins[5]   = i_oe[0] ? i_clk_out[0] : !i_assert;   // async1 clock pin
    assign o_pins[4:0] = {5{!i_assert}};
endmodule

// ===== bench/testbench.sv
// testbench: directed scenarios for the low-power pin controller
`timescale 1ns/10ps
module testbench;
    import lp_pin_pkg::*;
    logic clk = 1'b0, rst = 1'b1, a1i = 1'b1, csi = 1'b1, ioh = 1'b0, iol = 1'b0, cyc = 1'b0, drv = 1'b0;
    logic [1:0] mode = MODE_NORMAL, ctx = 2'h3, cclk = 2'h0;
    logic [15:0] addr = 16'h0000;
    logic [8:0] cs = 9'h1ff, so;
    logic [6:0] ci, pins;
    logic [4:0] pst;
    logic [1:0] txo;
    logic sel, sclk, pclk, a1o, a1oe, cso, csoe;
    int n_mismatch = 0, checked = 0, k;
    lp_pin_ctrl u_dut (.i_ref_clk(clk), .i_rst(rst), .i_mode_req(mode), .i_async1_clk_internal(a1i),
        .i_csio_clk_internal(csi), .i_io_base_bit_high(ioh), .i_io_base_bit_low(iol), .i_io_cycle(cyc),
        .i_io_addr(addr), .o_internal_select(sel), .i_core_rd_n(cs[8]), .i_core_wr_n(cs[7]),
        .i_core_memory_request_strobe_n(cs[6]), .i_core_io_request_strobe_n(cs[5]), .i_core_refresh_strobe_n(cs[4]),
        .i_core_first_cycle_strobe_n(cs[3]), .i_core_dma0_transfer_end_n(cs[2]), .i_core_dma1_transfer_end_n(cs[1]),
        .i_core_halt_n(cs[0]), .i_core_async1_transmit(ctx[1]), .i_core_clocked_serial_transmit(ctx[0]),
        .i_core_async1_clk(cclk[1]), .i_core_csio_clk(cclk[0]), .o_rd_n(so[8]), .o_wr_n(so[7]),
        .o_memory_request_strobe_n(so[6]), .o_io_request_strobe_n(so[5]), .o_refresh_strobe_n(so[4]),
        .o_first_cycle_strobe_n(so[3]), .o_dma0_transfer_end_n(so[2]), .o_dma1_transfer_end_n(so[1]),
        .o_halt_n(so[0]), .o_sys_clk(sclk), .o_periph_clk(pclk), .o_async1_transmit_out(txo[1]),
        .o_clocked_serial_transmit_out(txo[0]), .i_async1_clock_pin(pins[5]), .o_async1_clock_pin(a1o),
        .o_async1_clock_pin_oe(a1oe), .i_clocked_serial_clock_pin(pins[6]), .o_clocked_serial_clock_pin(cso),
        .o_clocked_serial_clock_pin_oe(csoe), .i_async1_receive_in(pins[0]), .i_async1_clear_to_send_n(pins[1]),
        .i_clocked_serial_receive_in(pins[2]), .i_dma0_request_in_n(pins[3]), .i_dma1_request_in_n(pins[4]),
        .o_core_async1_receive(ci[0]), .o_core_async1_clear_to_send_n(ci[1]), .o_core_clocked_serial_receive(ci[2]),
        .o_core_dma0_request_n(ci[3]), .o_core_dma1_request_n(ci[4]), .o_core_async1_clk(ci[5]),
        .o_core_csio_clk(ci[6]), .o_power_state(pst));
    link_partner_model u_far (.i_assert(drv), .i_oe({csoe, a1oe}), .i_clk_out({cso, a1o}), .o_pins(pins));

    // ****************************************
    // clock, helpers
    // ****************************************
    // reference clock
    initial begin
        forever #20 clk = !clk;
    end

    // wait edges, then settle past the edge
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // compare one value
    task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // request a mode and let the pins follow
    task automatic set_mode(input logic [1:0] m);
        mode = m;
        step(3);
        chk("power state", 9'(5'h01 << (m + 1)), 9'(pst));
    endtask

    // verdict
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    // pins while reset is held against active core and far-side levels, internal clock mode
    task automatic t_reset();
        logic s0;
        s0 = sclk;
        cs = 9'h000;
        ctx = 2'h0;
        drv = 1'b1;
        step(1);
        chk("sys clock", 9'(!s0), 9'(sclk));
        chk("strobes", 9'h1ff, so);
        chk("tx", 9'h3, 9'(txo));
        chk("clk oe", 9'h0, 9'({a1oe, csoe}));
        chk("pclk", 9'h0, 9'(pclk));
        chk("core in", 9'h7f, 9'(ci));
        cs = 9'h1ff;
        ctx = 2'h3;
        drv = 1'b0;
    endtask

    // page decode for each base: hit, wrong page, nonzero upper byte
    task automatic t_decode();
        for (int b = 0; b < 4; b++) begin
            {ioh, iol} = 2'(b);
            for (int t = 0; t < 3; t++) begin
                cyc = 1'b1;
                addr = {(t == 2) ? 8'h01 : 8'h00, (t == 1) ? 2'(b + 1) : 2'(b), 6'h15};
                step(1);
                chk("select", 9'(t == 0), 9'(sel));
                cyc = 1'b0;
                step(1);
                chk("select off", 9'h0, 9'(sel));
            end
        end
    endtask

    // strobes and peripheral clock in every mode with core strobes active
    task automatic t_strobes();
        logic [8:0] exp [4] = '{9'h000, 9'h1fe, 9'h000, 9'h1fe};
        logic p0;
        cs = 9'h000;
        for (int m = 0; m < 4; m++) begin
            set_mode(2'(m));
            chk("strobes", exp[m], so);
            k = 0;
            for (int i = 0; i < 8; i++) begin
                p0 = pclk;
                step(1);
                k += int'(pclk != p0);
            end
            chk("pclk toggles", 9'h4, 9'(k));
        end
        cs = 9'h1ff;
    endtask

    // transmit follows in sleep, holds through both stops
    task automatic t_tx();
        set_mode(MODE_SLEEP);
        ctx = 2'h0;
        step(2);
        chk("tx sleep", 9'h0, 9'(txo));
        set_mode(MODE_PSTOP);
        ctx = 2'h3;
        step(3);
        chk("tx pstop", 9'h0, 9'(txo));
        set_mode(MODE_SSTOP);
        chk("tx sstop", 9'h0, 9'(txo));
        set_mode(MODE_NORMAL);
        chk("tx normal", 9'h3, 9'(txo));
    endtask

    // far side asserts every input, external clock mode
    task automatic t_inputs();
        logic [8:0] exp [4] = '{9'h00, 9'h18, 9'h67, 9'h7f};
        {a1i, csi} = 2'h0;
        drv = 1'b1;
        for (int m = 0; m < 4; m++) begin
            set_mode(2'(m));
            step(6);
            chk("core in", exp[m], 9'(ci));
            chk("clk oe", 9'h0, 9'({a1oe, csoe}));
        end
        drv = 1'b0;
    endtask

    // internal clock mode: driven in sleep, serial clock forced high in stops
    task automatic t_clkpins();
        logic [8:0] exp [4] = '{9'h0, 9'hd, 9'h7, 9'h7};
        {a1i, csi} = 2'h3;
        cclk = 2'h2;
        for (int m = 1; m < 4; m++) begin
            set_mode(2'(m));
            chk("clk pins", exp[m], 9'({a1oe, csoe, cso, a1o}));
        end
        set_mode(MODE_NORMAL);
    endtask

    // main sequence
    initial begin
        step(2);
        t_reset();
        rst = 1'b0;
        step(2);
        t_decode();
        t_strobes();
        t_tx();
        t_inputs();
        t_clkpins();
        end_of_test();
    end

    // watchdog
    initial begin
        #100000;
        n_mismatch++;
        end_of_test();
    end
endmodule
